// ===== inc/pcsu_pkg.sv
// constants, types and behaviour summary for the program counter and return stack unit
// Behaviour
// - 13-bit counter, only low byte software visible
// - call, goto, low write load upper bits
// - eight entry 13-bit stack, pointer hidden
// - push on call and interrupt acknowledge
// - pop on return, literal return, interrupt return
// - push and pop leave holding register alone
// - ninth push overwrites the first entry
// - no overflow or underflow indication
// - branch target is eleven bits wide
// - page select comes from holding bit three
// - full 13-bit counter is pushed
// - holding bit four ignored for addressing
package pcsu_pkg;

  localparam int PC_W        = 13;
  localparam int LOW_W       = 8;
  localparam int UPPER_W     = 5;
  localparam int TGT_W       = 11;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;
  localparam int ADDR_W      = 4;
  localparam int DATA_W      = 32;
  localparam int PAGE_BIT    = 3;
  localparam int CLK_PERIOD_NS = 25;

  // register byte offsets on the bus
  localparam logic [ADDR_W-1:0] OFS_PC_LOW   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PC_UPPER = 4'h4;

  // values after reset, and the interrupt vector
  localparam logic [PC_W-1:0]    PC_RESET    = 13'h0000;
  localparam logic [UPPER_W-1:0] UPPER_RESET = 5'h00;
  localparam logic [SP_W-1:0]    SP_RESET    = 3'h0;
  localparam logic [PC_W-1:0]    IRQ_VECTOR  = 13'h0004;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // operations issued by the decode and execute logic
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_STEP      = 4'h1,
    OP_GOTO      = 4'h2,
    OP_CALL      = 4'h3,
    OP_LOW_WRITE = 4'h4,
    OP_RETURN    = 4'h5,
    OP_RET_LIT   = 4'h6,
    OP_RET_INT   = 4'h7,
    OP_IRQ_ACK   = 4'h8
  } pcsu_op_t;

  typedef struct packed {
    pcsu_op_t          op;
    logic [TGT_W-1:0]  target;
    logic [LOW_W-1:0]  low_data;
  } pcsu_cmd_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic            busy;
  } pcsu_stat_t;

  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_RESP = 2'b01
  } pcsu_wstate_t;

  typedef enum logic {
    RS_IDLE = 1'b0,
    RS_DATA = 1'b1
  } pcsu_rstate_t;

endpackage

// ===== verif/pcsu_core_model.sv
// behavioural model of the core decode and execute side
`timescale 1ns/100ps
module pcsu_core_model (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                req_valid,
  input  wire pcsu_pkg::pcsu_cmd_t req,
  output pcsu_pkg::pcsu_cmd_t      cmd
);
  import pcsu_pkg::*;
  ////////////////////////////////////////
  // one operation per cycle, idle after reset until software has set things up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd <= '{op: OP_NONE, target: '0, low_data: '0};
    end else if (req_valid) begin
      cmd <= req;
    end else begin
      // idle fields toggle so a stale operand is never mistaken for a live one
      cmd <= '{op: OP_NONE, target: ~cmd.target, low_data: ~cmd.low_data};
    end
  end
endmodule

// ===== verif/pcsu_top_tb.sv
// self-checking bench for the program counter and return stack unit
`timescale 1ns/100ps
module pcsu_top_tb;
  import pcsu_pkg::*;
  logic               aclk, aresetn, req_valid, crdy;
  pcsu_cmd_t          req, cmd;
  pcsu_stat_t         stat;
  logic [ADDR_W-1:0]  awaddr, araddr;
  logic [DATA_W-1:0]  wdata, rdata;
  logic [1:0]         bresp, rresp;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  int                 num_errors = 0;
  int                 num_checks = 0;
  int                 cyc = 0;
  logic [PC_W-1:0]    e_pc;
  logic [PC_W-1:0]    stk [STACK_DEPTH];
  logic [SP_W-1:0]    e_sp;
  logic [UPPER_W-1:0] e_hold;

  pcsu_core_model core_u (.aclk(aclk), .aresetn(aresetn), .req_valid(req_valid), .req(req), .cmd(cmd));
  pcsu_top dut_u (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .cmd_ready(crdy), .stat(stat),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////
  // 40 MHz clock and a hang guard well above the run length
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////
  // comparisons and closing report
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_pc(input logic [PC_W-1:0] e);
    cmp({19'h0, stat.pc}, {19'h0, e});
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    cmp({30'h0, g}, {30'h0, e});
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // bus master: address and data offered together, each released when taken
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    chk_resp(bresp, er);
    cmp({31'h0, stat.busy}, 32'h0000_0001);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    cmp(rdata, ed);
    chk_resp(rresp, er);
    rready <= 1'b0;
  endtask

  ////////////////////////////////////////
  // one core operation through the model, with the expected counter and stack kept alongside
  task automatic do_op(input pcsu_op_t o, input logic [TGT_W-1:0] t);
    case (o)
      OP_STEP: e_pc = e_pc + 13'h0001;
      OP_GOTO: e_pc = {1'b0, e_hold[PAGE_BIT], t};
      OP_LOW_WRITE: e_pc = {1'b0, e_hold[3:0], t[LOW_W-1:0]};
      OP_CALL: begin
        stk[e_sp] = e_pc + 13'h0001;
        e_sp++;
        e_pc = {1'b0, e_hold[PAGE_BIT], t};
      end
      OP_IRQ_ACK: begin
        stk[e_sp] = e_pc;
        e_sp++;
        e_pc = IRQ_VECTOR;
      end
      default: begin
        e_sp--;
        e_pc = stk[e_sp];
      end
    endcase
    @(posedge aclk);
    req <= '{op: o, target: t, low_data: t[LOW_W-1:0]};
    req_valid <= 1'b1;
    @(posedge aclk);
    req_valid <= 1'b0;
    @(posedge aclk);
    #1 chk_pc(e_pc);
  endtask

  ////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    chk_pc(PC_RESET);
    cmp({31'h0, crdy}, 32'h0000_0001);
    cmp({31'h0, stat.busy}, 32'h0000_0000);
    axi_rd(OFS_PC_LOW, 32'h0000_0000, RESP_OKAY);
    axi_rd(OFS_PC_UPPER, 32'h0000_0000, RESP_OKAY);
  endtask
  task automatic t_regs();
    axi_wr(OFS_PC_UPPER, 32'hFFFF_FF1F, RESP_OKAY);
    e_hold = 5'h1F;
    axi_rd(OFS_PC_UPPER, 32'h0000_001F, RESP_OKAY);
    axi_wr(OFS_PC_LOW, 32'h0000_00A5, RESP_OKAY);
    e_pc = {1'b0, e_hold[3:0], 8'hA5};
    #1 chk_pc(e_pc);
    axi_rd(OFS_PC_LOW, 32'h0000_00A5, RESP_OKAY);
    do_op(OP_LOW_WRITE, 11'h03C);
    axi_rd(OFS_PC_LOW, 32'h0000_003C, RESP_OKAY);
    axi_wr(4'h8, 32'h0000_0055, RESP_SLVERR);
    axi_rd(4'hC, 32'h0000_0000, RESP_SLVERR);
    chk_pc(e_pc);
  endtask
  task automatic t_branch();
    axi_wr(OFS_PC_UPPER, 32'h0000_0008, RESP_OKAY);
    e_hold = 5'h08;
    do_op(OP_GOTO, 11'h7FF);
    do_op(OP_STEP, 11'h000);
    axi_wr(OFS_PC_UPPER, 32'h0000_0000, RESP_OKAY);
    e_hold = 5'h00;
    do_op(OP_CALL, 11'h123);
    do_op(OP_IRQ_ACK, 11'h000);
    do_op(OP_RET_INT, 11'h000);
    do_op(OP_RET_LIT, 11'h000);
    axi_rd(OFS_PC_UPPER, 32'h0000_0000, RESP_OKAY);
  endtask
  task automatic t_wrap();
    pcsu_op_t rets [3];
    rets = '{OP_RETURN, OP_RET_LIT, OP_RET_INT};
    // nine calls wrap the eight entries; nine pops then run past empty
    for (int i = 0; i < 9; i++) begin
      do_op(OP_GOTO, TGT_W'(i * 16));
      do_op(OP_CALL, TGT_W'(i + 1024));
    end
    for (int i = 0; i < 9; i++) begin
      do_op(rets[i % 3], 11'h000);
    end
    axi_rd(OFS_PC_UPPER, 32'h0000_0000, RESP_OKAY);
  endtask
  // call and return on consecutive cycles must come straight back past the call
  task automatic t_pair();
    @(posedge aclk);
    req <= '{op: OP_CALL, target: 11'h2AA, low_data: 8'h00};
    req_valid <= 1'b1;
    @(posedge aclk);
    req <= '{op: OP_RETURN, target: 11'h000, low_data: 8'h00};
    @(posedge aclk);
    req_valid <= 1'b0;
    @(posedge aclk);
    stk[e_sp] = e_pc + 13'h0001;
    e_pc = stk[e_sp];
    #1 chk_pc(e_pc);
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    aresetn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    e_pc = PC_RESET;
    e_sp = SP_RESET;
    e_hold = UPPER_RESET;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1 t_reset();
    t_regs();
    t_branch();
    t_wrap();
    t_pair();
    wrap_up();
  end
endmodule

// ===== verilog/pcsu_top.sv
// program counter, holding register and circular return stack with an axi4-lite register slave
`timescale 1ns/100ps
module pcsu_top (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire pcsu_pkg::pcsu_cmd_t          cmd,
  output logic                              cmd_ready,
  output pcsu_pkg::pcsu_stat_t              stat,
  input  wire logic [pcsu_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [pcsu_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [pcsu_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [pcsu_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready
);
  import pcsu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // word offset check, shared by the write and read paths
  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    is_reg = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // upper counter bits as addressing sees them: bit four never reaches the counter
  function automatic logic [UPPER_W-1:0] eff_upper(input logic [UPPER_W-1:0] h);
    eff_upper = {1'b0, h[UPPER_W-2:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [PC_W-1:0]    pc;
  logic [PC_W-1:0]    next_pc;
  logic [UPPER_W-1:0] pc_upper_holding;
  logic [UPPER_W-1:0] next_pc_upper_holding;
  logic [PC_W-1:0]    stack [STACK_DEPTH];
  logic [PC_W-1:0]    next_stack [STACK_DEPTH];
  logic [SP_W-1:0]    sp;
  logic [SP_W-1:0]    next_sp;

  pcsu_wstate_t       wstate;
  pcsu_wstate_t       next_wstate;
  logic               aw_held;
  logic               next_aw_held;
  logic [ADDR_W-1:0]  aw_addr;
  logic [ADDR_W-1:0]  next_aw_addr;
  logic               w_held;
  logic               next_w_held;
  logic [DATA_W-1:0]  w_data;
  logic [DATA_W-1:0]  next_w_data;
  logic [3:0]         w_strb;
  logic [3:0]         next_w_strb;
  logic [1:0]         bresp;
  logic [1:0]         next_bresp;

  pcsu_rstate_t       rstate;
  pcsu_rstate_t       next_rstate;
  logic [DATA_W-1:0]  rdata;
  logic [DATA_W-1:0]  next_rdata;
  logic [1:0]         rresp;
  logic [1:0]         next_rresp;

  logic               core_busy;
  logic               commit;
  logic               do_push;
  logic               do_pop;
  logic [SP_W-1:0]    sp_dec;
  logic [PC_W-1:0]    push_val;
  logic [UPPER_W-1:0] eff_hold;

  ////////////////////////////////////////////////////////////////////////////
  // bus write path

  // a bus write only lands in a cycle with no core operation, so a low byte
  // write can never collide with a branch; the core is never stalled
  assign core_busy     = (cmd.op != OP_NONE);
  assign commit        = aw_held && w_held && (wstate == WS_IDLE) && !core_busy;
  assign s_axi_awready = !aw_held && (wstate == WS_IDLE);
  assign s_axi_wready  = !w_held && (wstate == WS_IDLE);
  assign s_axi_bvalid  = (wstate == WS_RESP);
  assign s_axi_bresp   = bresp;
  assign cmd_ready     = 1'b1;

  // address and data are caught independently, answer follows both
  always_comb begin
    next_wstate  = wstate;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bresp   = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    unique case (wstate)
      WS_IDLE: begin
        if (commit) begin
          next_wstate  = WS_RESP;
          next_aw_held = 1'b0;
          next_w_held  = 1'b0;
          next_bresp   = (is_reg(aw_addr, OFS_PC_LOW) || is_reg(aw_addr, OFS_PC_UPPER)) ? RESP_OKAY : RESP_SLVERR;
        end
      end
      WS_RESP: begin
        if (s_axi_bready) begin
          next_wstate = WS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate  <= WS_IDLE;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= '0;
      w_strb  <= 4'h0;
      bresp   <= RESP_OKAY;
    end else begin
      wstate  <= next_wstate;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bresp   <= next_bresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read path

  assign s_axi_arready = (rstate == RS_IDLE);
  assign s_axi_rvalid  = (rstate == RS_DATA);
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  // only the low byte of the counter is visible; upper counter bits stay hidden
  always_comb begin
    next_rstate = rstate;
    next_rdata  = rdata;
    next_rresp  = rresp;
    unique case (rstate)
      RS_IDLE: begin
        if (s_axi_arvalid) begin
          next_rstate = RS_DATA;
          next_rresp  = RESP_OKAY;
          if (is_reg(s_axi_araddr, OFS_PC_LOW)) begin
            next_rdata = {24'h000000, pc[LOW_W-1:0]};
          end else if (is_reg(s_axi_araddr, OFS_PC_UPPER)) begin
            next_rdata = {27'h0000000, pc_upper_holding};
          end else begin
            next_rdata = 32'h00000000;
            next_rresp = RESP_SLVERR;
          end
        end
      end
      RS_DATA: begin
        if (s_axi_rready) begin
          next_rstate = RS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate <= RS_IDLE;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else begin
      rstate <= next_rstate;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter, holding register and return stack

  // pointer names the next free slot; arithmetic wraps modulo eight silently
  assign sp_dec  = sp - 3'h1;
  assign do_push = (cmd.op == OP_CALL) || (cmd.op == OP_IRQ_ACK);
  assign do_pop  = (cmd.op == OP_RETURN) || (cmd.op == OP_RET_LIT) || (cmd.op == OP_RET_INT);
  // a call returns past itself, an interrupt resumes the interrupted word
  assign push_val = (cmd.op == OP_CALL) ? (pc + 13'h0001) : pc;
  // holding bits as the counter sees them; a part-select cannot sit on a call result
  assign eff_hold = eff_upper(pc_upper_holding);

  always_comb begin
    next_pc               = pc;
    next_pc_upper_holding = pc_upper_holding;
    next_sp               = sp;
    next_stack            = stack;
    unique case (cmd.op)
      OP_NONE: begin
        // bus writes land only here, the core owns every other cycle
        if (commit && w_strb[0] && is_reg(aw_addr, OFS_PC_LOW)) begin
          next_pc = {eff_upper(pc_upper_holding), w_data[LOW_W-1:0]};
        end
        if (commit && w_strb[0] && is_reg(aw_addr, OFS_PC_UPPER)) begin
          next_pc_upper_holding = w_data[UPPER_W-1:0];
        end
      end
      OP_STEP: begin
        next_pc = pc + 13'h0001;
      end
      OP_GOTO: begin
        next_pc = {eff_hold[UPPER_W-1:PAGE_BIT], cmd.target};
      end
      OP_CALL: begin
        next_stack[sp] = push_val;
        next_sp        = sp + 3'h1;
        next_pc        = {eff_hold[UPPER_W-1:PAGE_BIT], cmd.target};
      end
      OP_LOW_WRITE: begin
        next_pc = {eff_upper(pc_upper_holding), cmd.low_data};
      end
      OP_RETURN, OP_RET_LIT, OP_RET_INT: begin
        // an empty stack still pops: stale data, no flag raised
        next_pc = stack[sp_dec];
        next_sp = sp_dec;
      end
      OP_IRQ_ACK: begin
        next_stack[sp] = push_val;
        next_sp        = sp + 3'h1;
        next_pc        = IRQ_VECTOR;
      end
      default: begin
        next_pc = pc;
      end
    endcase
  end

  // holding register reset is defined here even though software must not rely on it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc               <= PC_RESET;
      pc_upper_holding <= UPPER_RESET;
      sp               <= SP_RESET;
    end else begin
      pc               <= next_pc;
      pc_upper_holding <= next_pc_upper_holding;
      sp               <= next_sp;
    end
  end

  // stack contents are data only, so they carry no reset
  always_ff @(posedge aclk) begin
    stack <= next_stack;
  end

  assign stat = '{pc: pc, busy: (wstate != WS_IDLE)};

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_low_write_load: assert property (
    cmd.op == OP_LOW_WRITE |=> pc == {1'b0, $past(pc_upper_holding[3:0]), $past(cmd.low_data)})
    else $error("low byte write did not load upper bits from holding register");

  chk_goto_page_sel: assert property (
    cmd.op == OP_GOTO |=> (pc[12] == 1'b0) && (pc[11] == $past(pc_upper_holding[3]))
      && (pc[10:0] == $past(cmd.target)))
    else $error("jump target or page bit wrong");

  chk_call_push_ret: assert property (
    cmd.op == OP_CALL |=> stack[$past(sp)] == $past(pc) + 13'h0001 ##0 sp == $past(sp) + 3'h1)
    else $error("call did not push the full return address");

  chk_irq_push_vec: assert property (
    cmd.op == OP_IRQ_ACK |=> pc == IRQ_VECTOR && stack[$past(sp)] == $past(pc))
    else $error("interrupt acknowledge did not push and vector");

  chk_pop_restore: assert property (
    (cmd.op == OP_RETURN || cmd.op == OP_RET_LIT || cmd.op == OP_RET_INT)
      |=> pc == $past(stack[sp - 3'h1]) && sp == $past(sp) - 3'h1)
    else $error("return did not restore the counter from the stack");

  chk_stack_holding: assert property (
    (cmd.op == OP_CALL || cmd.op == OP_IRQ_ACK || cmd.op == OP_RETURN || cmd.op == OP_RET_LIT
      || cmd.op == OP_RET_INT) |=> $stable(pc_upper_holding))
    else $error("stack operation disturbed the holding register");

  chk_call_ret_pair: assert property (
    cmd.op == OP_CALL ##1 cmd.op == OP_RETURN |=> pc == $past(pc, 2) + 13'h0001)
    else $error("call followed by return did not come back");

  chk_bus_low_load: assert property (
    commit && w_strb[0] && is_reg(aw_addr, OFS_PC_LOW)
      |=> pc[7:0] == $past(w_data[7:0]) && pc[12:8] == {1'b0, $past(pc_upper_holding[3:0])} && s_axi_bvalid)
    else $error("bus low byte write did not load the counter");

  chk_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");

  chk_sp_idle_hold: assert property (
    (cmd.op == OP_NONE || cmd.op == OP_STEP || cmd.op == OP_GOTO || cmd.op == OP_LOW_WRITE) |=> $stable(sp))
    else $error("stack pointer moved without a push or pop");

  chk_holding_load: assert property (
    commit && w_strb[0] && is_reg(aw_addr, OFS_PC_UPPER) |=> pc_upper_holding == $past(w_data[4:0]))
    else $error("bus write did not load the holding register");

  chk_refused_write: assert property (
    commit && !is_reg(aw_addr, OFS_PC_LOW) && !is_reg(aw_addr, OFS_PC_UPPER)
      |=> $stable(pc) && $stable(pc_upper_holding) && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write changed state or was not refused");

  chk_read_low_only: assert property (
    s_axi_arvalid && s_axi_arready && is_reg(s_axi_araddr, OFS_PC_LOW)
      |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(pc[7:0])})
    else $error("low byte read returned wrong data");

  chk_read_holding: assert property (
    s_axi_arvalid && s_axi_arready && is_reg(s_axi_araddr, OFS_PC_UPPER)
      |=> s_axi_rvalid && s_axi_rdata == {27'h0000000, $past(pc_upper_holding)})
    else $error("holding register read returned wrong data");

endmodule
